// *** logic/dcm_diag_core.sv ***
// Per-valve diagnostic condition words, pin summary and load fault flags behind an Avalon-MM slave.
`timescale 1ns/1ns
`default_nettype none
`include "dcm_regs.svh"

module dcm_diag_core #(
    parameter int CNT_W     = 32,
    parameter int DUR_W     = 32,
    parameter int TEMP_W    = 16,
    parameter int BLINK_CYC = `DCM_BLINK_CYC
) (
    input  wire logic              mclk_in,                 // System clock, 125 MHz.
    input  wire logic              reset_in,                // Synchronous active-high reset.
    input  wire logic [3:0]        avs_address_in,          // Word address.
    input  wire logic              avs_read_in,             // Read request.
    input  wire logic              avs_write_in,            // Write request.
    input  wire logic [31:0]       avs_writedata_in,        // Write data.
    input  wire logic [3:0]        avs_byteenable_in,       // Byte enables.
    output logic      [31:0]       avs_readdata_out,        // Read data.
    output logic                   avs_waitrequest_out,     // Stall until answer.
    input  wire logic [CNT_W-1:0]  stroke_counter_a_in,     // Valve 1 stroke counter.
    input  wire logic [CNT_W-1:0]  stroke_counter_b_in,     // Valve 2 stroke counter.
    input  wire logic [DUR_W-1:0]  stroke_duration_a_in,    // Valve 1 last stroke duration.
    input  wire logic [DUR_W-1:0]  stroke_duration_b_in,    // Valve 2 last stroke duration.
    input  wire logic              std_transducer_a_bad_in, // Valve 1 transducer bad.
    input  wire logic              std_transducer_b_bad_in, // Valve 2 transducer bad.
    input  wire logic signed [TEMP_W-1:0] board_temp_in,    // Board temperature.
    input  wire logic [5:0]        config_switch_in,        // Switches 0..5 on.
    input  wire logic              load_driver_zero_in,     // Driver 0 energized.
    input  wire logic              load_driver_one_in,      // Driver 1 energized.
    input  wire logic              dry_contact_input_one_in, // Input one shorted.
    input  wire logic              dry_contact_input_two_in, // Input two shorted.
    input  wire logic              upper_magnet_sensor_in,  // Upper sensor sees magnet.
    input  wire logic              lower_magnet_sensor_in,  // Lower sensor sees magnet.
    input  wire logic [1:0]        load_short_sense_in,     // Per-driver short sense.
    input  wire logic [1:0]        load_open_sense_in,      // Per-driver open sense.
    output logic      [4:0]        binary_in_a_out,         // Valve 1 word to binary input.
    output logic      [4:0]        binary_in_b_out,         // Valve 2 word to binary input.
    output logic      [3:0]        load_status_out,         // Short0, open0, short1, open1.
    output logic      [1:0]        driver_led_out           // Driver LEDs.
);
    if (CNT_W < 1 || CNT_W > 32 || DUR_W < 1 || DUR_W > 32 ||
        TEMP_W < 2 || TEMP_W > 16 || BLINK_CYC < 2) begin : g_bad_params
        $error("dcm_diag_core: unsupported parameter value");
    end

    dcm_pkg::dcm_cond_t mask_ff [2];
    dcm_pkg::dcm_cond_t flags_ff [2];
    logic [CNT_W-1:0]   cnt_lim_ff [2];
    logic [DUR_W-1:0]   dur_lim_ff [2];
    logic signed [TEMP_W-1:0] temp_hi_ff;
    logic signed [TEMP_W-1:0] temp_lo_ff;
    dcm_pkg::dcm_pins_t pins_ff;
    logic [3:0]         load_ff;
    logic [31:0]        blink_cnt_ff;
    logic               blink_ff;
    dcm_pkg::dcm_bus_e  bus_ff;
    logic [31:0]        nxt_rdata;

    wire logic [CNT_W-1:0] cnt_in [2] = '{stroke_counter_a_in, stroke_counter_b_in};
    wire logic [DUR_W-1:0] dur_in [2] = '{stroke_duration_a_in, stroke_duration_b_in};
    wire logic             bad_in [2] = '{std_transducer_a_bad_in, std_transducer_b_bad_in};
    wire logic             wr_go = avs_write_in && bus_ff == dcm_pkg::DCM_BUS_IDLE;

    // Each valve channel has its own mask and condition word; nothing is shared except the temperature limits.
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        dcm_pkg::dcm_cond_t raw;
        always_comb begin
            raw = 5'h00;
            raw[`DCM_BIT_CNT]  = cnt_in[ch] > cnt_lim_ff[ch];
            raw[`DCM_BIT_DUR]  = dur_in[ch] > dur_lim_ff[ch];
            raw[`DCM_BIT_XDCR] = bad_in[ch];
            raw[`DCM_BIT_HOT]  = board_temp_in > temp_hi_ff;
            raw[`DCM_BIT_COLD] = board_temp_in < temp_lo_ff;
        end

        // Mask writes do not depend on any mode of the owning block.
        always_ff @(posedge mclk_in) begin
            if (reset_in) begin
                mask_ff[ch] <= `DCM_RST_MASK;
            end else if (wr_go && avs_byteenable_in[0] &&
                         avs_address_in == (ch == 0 ? `DCM_OFS_MASK0 : `DCM_OFS_MASK1)) begin
                mask_ff[ch] <= avs_writedata_in[4:0];
            end
        end

        // Recomputed every cycle from live conditions, so a cleared condition drops its bit at once.
        always_ff @(posedge mclk_in) begin
            if (reset_in) begin
                flags_ff[ch] <= 5'h00;
            end else begin
                flags_ff[ch] <= raw & mask_ff[ch];
            end
        end

        always_ff @(posedge mclk_in) begin
            if (reset_in) begin
                cnt_lim_ff[ch] <= CNT_W'(`DCM_RST_LIMIT);
                dur_lim_ff[ch] <= DUR_W'(`DCM_RST_LIMIT);
            end else if (wr_go) begin
                if (avs_address_in == (ch == 0 ? `DCM_OFS_CNTLIM0 : `DCM_OFS_CNTLIM1))
                    cnt_lim_ff[ch] <= avs_writedata_in[CNT_W-1:0];
                if (avs_address_in == (ch == 0 ? `DCM_OFS_DURLIM0 : `DCM_OFS_DURLIM1))
                    dur_lim_ff[ch] <= avs_writedata_in[DUR_W-1:0];
            end
        end

        chk_flag_tracks_raw: assert property (@(posedge mclk_in) disable iff (reset_in)
            !$past(reset_in) |-> flags_ff[ch] == ($past(raw) & $past(mask_ff[ch])))
            else $error("condition word does not follow masked conditions");
        chk_count_strict: assert property (@(posedge mclk_in) disable iff (reset_in)
            (cnt_in[ch] == cnt_lim_ff[ch]) ##1 !$past(reset_in) |-> !flags_ff[ch][`DCM_BIT_CNT])
            else $error("stroke count flag set at equal value");
        chk_masked_off: assert property (@(posedge mclk_in) disable iff (reset_in)
            (mask_ff[ch] == 5'h00) ##1 !$past(reset_in) |-> flags_ff[ch] == 5'h00)
            else $error("flag set for a disabled condition");

        // Each condition is checked on its own so that a wrong bit position shows up by name.
        sequence s_cnt_over;
            cnt_in[ch] > cnt_lim_ff[ch] && mask_ff[ch][`DCM_BIT_CNT];
        endsequence
        sequence s_dur_over;
            dur_in[ch] > dur_lim_ff[ch] && mask_ff[ch][`DCM_BIT_DUR];
        endsequence
        sequence s_too_hot;
            board_temp_in > temp_hi_ff && mask_ff[ch][`DCM_BIT_HOT];
        endsequence
        sequence s_too_cold;
            board_temp_in < temp_lo_ff && mask_ff[ch][`DCM_BIT_COLD];
        endsequence
        sequence s_mask_write;
            wr_go && avs_byteenable_in[0] && avs_address_in == (ch == 0 ? `DCM_OFS_MASK0 : `DCM_OFS_MASK1);
        endsequence

        chk_count_over: assert property (@(posedge mclk_in) disable iff (reset_in)
            s_cnt_over ##1 !$past(reset_in) |-> flags_ff[ch][`DCM_BIT_CNT])
            else $error("stroke count flag missing above limit");
        chk_dur_over: assert property (@(posedge mclk_in) disable iff (reset_in)
            s_dur_over ##1 !$past(reset_in) |-> flags_ff[ch][`DCM_BIT_DUR])
            else $error("stroke duration flag missing above limit");
        chk_dur_equal: assert property (@(posedge mclk_in) disable iff (reset_in)
            (dur_in[ch] == dur_lim_ff[ch]) ##1 !$past(reset_in) |-> !flags_ff[ch][`DCM_BIT_DUR])
            else $error("stroke duration flag set at equal value");
        chk_xdcr_flag: assert property (@(posedge mclk_in) disable iff (reset_in)
            (bad_in[ch] && mask_ff[ch][`DCM_BIT_XDCR]) ##1 !$past(reset_in) |-> flags_ff[ch][`DCM_BIT_XDCR])
            else $error("transducer flag missing on bad status");
        chk_hot_flag: assert property (@(posedge mclk_in) disable iff (reset_in)
            s_too_hot ##1 !$past(reset_in) |-> flags_ff[ch][`DCM_BIT_HOT])
            else $error("upper temperature flag missing");
        chk_cold_flag: assert property (@(posedge mclk_in) disable iff (reset_in)
            s_too_cold ##1 !$past(reset_in) |-> flags_ff[ch][`DCM_BIT_COLD])
            else $error("lower temperature flag missing");
        chk_word_clears: assert property (@(posedge mclk_in) disable iff (reset_in)
            (raw == 5'h00) ##1 !$past(reset_in) |-> flags_ff[ch] == 5'h00)
            else $error("condition word held after conditions ceased");
        chk_mask_write: assert property (@(posedge mclk_in) disable iff (reset_in)
            s_mask_write ##1 !$past(reset_in) |-> mask_ff[ch] == $past(avs_writedata_in[4:0]))
            else $error("mask write not accepted");
        chk_mask_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
            !(wr_go && avs_address_in == (ch == 0 ? `DCM_OFS_MASK0 : `DCM_OFS_MASK1)) ##1 !$past(reset_in)
            |-> $stable(mask_ff[ch]))
            else $error("mask changed without a write to it");
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            binary_in_a_out <= 5'h00;
            binary_in_b_out <= 5'h00;
        end else begin
            binary_in_a_out <= flags_ff[0];
            binary_in_b_out <= flags_ff[1];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            temp_hi_ff <= TEMP_W'(`DCM_RST_TEMPHI);
            temp_lo_ff <= TEMP_W'(`DCM_RST_TEMPLO);
        end else if (wr_go) begin
            if (avs_address_in == `DCM_OFS_TEMPHI)
                temp_hi_ff <= avs_writedata_in[TEMP_W-1:0];
            if (avs_address_in == `DCM_OFS_TEMPLO)
                temp_lo_ff <= avs_writedata_in[TEMP_W-1:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pins_ff <= 16'h0000;
        end else begin
            pins_ff <= {4'h0,
                        lower_magnet_sensor_in, upper_magnet_sensor_in,
                        dry_contact_input_two_in, dry_contact_input_one_in,
                        load_driver_one_in, load_driver_zero_in,
                        config_switch_in};
        end
    end

    // Faults are only qualified while the driver is energized, so an idle output never reports open.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            load_ff <= 4'h0;
        end else begin
            load_ff <= {load_open_sense_in[1] & load_driver_one_in,
                        load_short_sense_in[1] & load_driver_one_in,
                        load_open_sense_in[0] & load_driver_zero_in,
                        load_short_sense_in[0] & load_driver_zero_in};
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            blink_cnt_ff <= 32'h0000_0000;
            blink_ff     <= 1'b0;
        end else if (blink_cnt_ff >= 32'(BLINK_CYC - 1)) begin
            blink_cnt_ff <= 32'h0000_0000;
            blink_ff     <= ~blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
        end
    end

    // A faulted driver's LED blinks; otherwise it mirrors the driver state.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            driver_led_out  <= 2'b00;
            load_status_out <= 4'h0;
        end else begin
            driver_led_out[0] <= (load_ff[1:0] != 2'b00) ? blink_ff : load_driver_zero_in;
            driver_led_out[1] <= (load_ff[3:2] != 2'b00) ? blink_ff : load_driver_one_in;
            load_status_out   <= load_ff;
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (avs_address_in)
            `DCM_OFS_MASK0:   nxt_rdata = {27'h0, mask_ff[0]};
            `DCM_OFS_MASK1:   nxt_rdata = {27'h0, mask_ff[1]};
            `DCM_OFS_FLAGS0:  nxt_rdata = {27'h0, flags_ff[0]};
            `DCM_OFS_FLAGS1:  nxt_rdata = {27'h0, flags_ff[1]};
            `DCM_OFS_PINS:    nxt_rdata = {16'h0, pins_ff};
            `DCM_OFS_LOAD:    nxt_rdata = {28'h0, load_ff};
            `DCM_OFS_CNTLIM0: nxt_rdata = 32'(cnt_lim_ff[0]);
            `DCM_OFS_CNTLIM1: nxt_rdata = 32'(cnt_lim_ff[1]);
            `DCM_OFS_DURLIM0: nxt_rdata = 32'(dur_lim_ff[0]);
            `DCM_OFS_DURLIM1: nxt_rdata = 32'(dur_lim_ff[1]);
            `DCM_OFS_TEMPHI:  nxt_rdata = 32'(unsigned'(temp_hi_ff));
            `DCM_OFS_TEMPLO:  nxt_rdata = 32'(unsigned'(temp_lo_ff));
            default:          nxt_rdata = 32'h0000_0000;
        endcase
    end

    // One wait cycle per access keeps read data registered; unmapped addresses read zero.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            bus_ff              <= dcm_pkg::DCM_BUS_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else begin
            unique case (bus_ff)
                dcm_pkg::DCM_BUS_IDLE: begin
                    avs_waitrequest_out <= 1'b1;
                    if (avs_read_in || avs_write_in) begin
                        bus_ff              <= dcm_pkg::DCM_BUS_ACK;
                        avs_waitrequest_out <= 1'b0;
                        avs_readdata_out    <= avs_read_in ? nxt_rdata : 32'h0000_0000;
                    end
                end
                dcm_pkg::DCM_BUS_ACK: begin
                    bus_ff              <= dcm_pkg::DCM_BUS_IDLE;
                    avs_waitrequest_out <= 1'b1;
                end
            endcase
        end
    end

    sequence s_fault_seen;
        load_driver_zero_in && load_open_sense_in[0];
    endsequence
    chk_open_reported: assert property (@(posedge mclk_in) disable iff (reset_in)
        s_fault_seen ##1 !$past(reset_in) |-> ##1 load_status_out[1])
        else $error("open load on active driver not reported");
    chk_no_idle_open: assert property (@(posedge mclk_in) disable iff (reset_in)
        !load_driver_one_in ##1 !$past(reset_in) |-> !load_ff[3])
        else $error("open load flagged on idle driver");
    chk_pin_reserved: assert property (@(posedge mclk_in) disable iff (reset_in)
        pins_ff[15:12] == 4'h0)
        else $error("reserved summary bits set");
    chk_output_zero: assert property (@(posedge mclk_in) disable iff (reset_in)
        (flags_ff[0] == 5'h00) ##1 !$past(reset_in) |-> binary_in_a_out == 5'h00)
        else $error("binary output not zero after conditions cease");
    chk_bus_one_wait: assert property (@(posedge mclk_in) disable iff (reset_in)
        (bus_ff == dcm_pkg::DCM_BUS_IDLE && avs_write_in) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("write not answered after one cycle");

    sequence s_short_zero;
        load_driver_zero_in && load_short_sense_in[0];
    endsequence
    sequence s_short_one;
        load_driver_one_in && load_short_sense_in[1];
    endsequence
    sequence s_open_one;
        load_driver_one_in && load_open_sense_in[1];
    endsequence
    chk_short0_reported: assert property (@(posedge mclk_in) disable iff (reset_in)
        s_short_zero ##1 !$past(reset_in) |-> ##1 load_status_out[0])
        else $error("short load on driver zero not reported");
    chk_short1_reported: assert property (@(posedge mclk_in) disable iff (reset_in)
        s_short_one ##1 !$past(reset_in) |-> ##1 load_status_out[2])
        else $error("short load on driver one not reported");
    chk_open1_reported: assert property (@(posedge mclk_in) disable iff (reset_in)
        s_open_one ##1 !$past(reset_in) |-> ##1 load_status_out[3])
        else $error("open load on driver one not reported");
    chk_no_idle_open0: assert property (@(posedge mclk_in) disable iff (reset_in)
        !load_driver_zero_in ##1 !$past(reset_in) |-> !load_ff[1])
        else $error("open load flagged on idle driver zero");
    chk_fault_clears: assert property (@(posedge mclk_in) disable iff (reset_in)
        (load_short_sense_in == 2'b00 && load_open_sense_in == 2'b00) ##1 !$past(reset_in) |-> load_ff == 4'h0)
        else $error("load fault flag held after fault ceased");

    // The blink phase is one flop wide, so the LEDs of all faulted drivers blink together.
    chk_led_blinks: assert property (@(posedge mclk_in) disable iff (reset_in)
        (load_ff[3:2] != 2'b00) ##1 !$past(reset_in) |-> driver_led_out[1] == $past(blink_ff))
        else $error("faulted driver LED does not blink");
    chk_led_follows0: assert property (@(posedge mclk_in) disable iff (reset_in)
        (load_ff[1:0] == 2'b00) ##1 !$past(reset_in) |-> driver_led_out[0] == $past(load_driver_zero_in))
        else $error("healthy driver zero LED does not follow the driver");
    chk_led_follows1: assert property (@(posedge mclk_in) disable iff (reset_in)
        (load_ff[3:2] == 2'b00) ##1 !$past(reset_in) |-> driver_led_out[1] == $past(load_driver_one_in))
        else $error("healthy driver one LED does not follow the driver");
    chk_blink_bound: assert property (@(posedge mclk_in) disable iff (reset_in)
        blink_cnt_ff <= 32'(BLINK_CYC - 1))
        else $error("blink counter ran past its period");
    chk_out_word_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        !$past(reset_in) |-> binary_in_a_out == $past(flags_ff[0]))
        else $error("valve one output differs from its condition word");
    chk_out_word_b: assert property (@(posedge mclk_in) disable iff (reset_in)
        !$past(reset_in) |-> binary_in_b_out == $past(flags_ff[1]))
        else $error("valve two output differs from its condition word");
    chk_pins_track: assert property (@(posedge mclk_in) disable iff (reset_in)
        !$past(reset_in) |-> pins_ff[11:0] == $past({lower_magnet_sensor_in, upper_magnet_sensor_in,
            dry_contact_input_two_in, dry_contact_input_one_in,
            load_driver_one_in, load_driver_zero_in, config_switch_in}))
        else $error("pin summary does not follow the pins");

    // No reset guard here: the first edge after release is exactly the one that must see cleared state.
    chk_reset_clears: assert property (@(posedge mclk_in)
        ($past(reset_in) && !reset_in) |-> mask_ff[0] == 5'h00 && mask_ff[1] == 5'h00 && flags_ff[0] == 5'h00 &&
            flags_ff[1] == 5'h00 && load_ff == 4'h0 && binary_in_a_out == 5'h00 && binary_in_b_out == 5'h00)
        else $error("reset left a mask or flag set");
endmodule
`default_nettype wire

// *** include/dcm_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the diagnostic condition block.
`ifndef DCM_REGS_SVH
`define DCM_REGS_SVH
`define DCM_OFS_MASK0       4'h0
`define DCM_OFS_MASK1       4'h1
`define DCM_OFS_FLAGS0      4'h2
`define DCM_OFS_FLAGS1      4'h3
`define DCM_OFS_PINS        4'h4
`define DCM_OFS_LOAD        4'h5
`define DCM_OFS_CNTLIM0     4'h6
`define DCM_OFS_CNTLIM1     4'h7
`define DCM_OFS_DURLIM0     4'h8
`define DCM_OFS_DURLIM1     4'h9
`define DCM_OFS_TEMPHI      4'hA
`define DCM_OFS_TEMPLO      4'hB
`define DCM_BIT_CNT         0
`define DCM_BIT_DUR         1
`define DCM_BIT_XDCR        2
`define DCM_BIT_HOT         3
`define DCM_BIT_COLD        4
`define DCM_RST_MASK        5'h00
`define DCM_RST_LIMIT       32'h0000_0000
`define DCM_RST_TEMPHI      16'sh7FFF
`define DCM_RST_TEMPLO      16'sh8000
`define DCM_BLINK_MS        250
`define DCM_CLK_KHZ         125000
`define DCM_BLINK_CYC       (`DCM_BLINK_MS * `DCM_CLK_KHZ)
`endif

// *** include/dcm_pkg.sv ***
// Types shared by the diagnostic condition block.
package dcm_pkg;
    typedef logic [4:0]  dcm_cond_t;
    typedef logic [15:0] dcm_pins_t;
    typedef enum logic [1:0] {
        DCM_BUS_IDLE,
        DCM_BUS_ACK
    } dcm_bus_e;
endpackage

// *** dv/dcm_binary_in_func.sv ***
// Model of the consuming binary-input function that picks one valve's condition word by channel code.
`timescale 1ns/1ns
`default_nettype none
module dcm_binary_in_func #(
    parameter int CHANNEL = 13
) (
    input  wire logic [4:0] word_a_in,  // Valve 1 condition word.
    input  wire logic [4:0] word_b_in,  // Valve 2 condition word.
    output logic      [4:0] out_d_out   // Value the function block reports.
);
    // An unknown channel code selects nothing, so the output then reads zero.
    always_comb begin
        case (CHANNEL)
            13:      out_d_out = word_a_in;
            213:     out_d_out = word_b_in;
            default: out_d_out = 5'h00;
        endcase
    end
endmodule
`default_nettype wire

// *** dv/dcm_diag_core_test.sv ***
// Self-checking testbench of the diagnostic condition block.
`timescale 1ns/1ns
`default_nettype none
`include "dcm_regs.svh"
module dcm_diag_core_test;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wrq = 1'b0, bad_b = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, cnt_a = 32'h0, cnt_b = 32'h0, dur_a = 32'h0, dur_b = 32'h0;
    logic        wait_o, bad_a = 1'b0, drv0 = 1'b0, drv1 = 1'b0, dc1 = 1'b0, dc2 = 1'b0, up = 1'b0, lo = 1'b0;
    logic [15:0] temp = 16'h0;
    logic [5:0]  sw = 6'h00;
    logic [1:0]  shrt = 2'h0, opn = 2'h0, led;
    logic [4:0]  bin_a, bin_b, di13, di213;
    logic [3:0]  lstat;
    int          bad_count = 0, comparisons = 0;
    initial forever #4 clk = ~clk;
    dcm_diag_core #(.BLINK_CYC(4)) i_dut (.mclk_in(clk), .reset_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wrq), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o), .stroke_counter_a_in(cnt_a),
        .stroke_counter_b_in(cnt_b), .stroke_duration_a_in(dur_a), .stroke_duration_b_in(dur_b),
        .std_transducer_a_bad_in(bad_a), .std_transducer_b_bad_in(bad_b), .board_temp_in(temp),
        .config_switch_in(sw), .load_driver_zero_in(drv0), .load_driver_one_in(drv1),
        .dry_contact_input_one_in(dc1), .dry_contact_input_two_in(dc2), .upper_magnet_sensor_in(up),
        .lower_magnet_sensor_in(lo), .load_short_sense_in(shrt), .load_open_sense_in(opn),
        .binary_in_a_out(bin_a), .binary_in_b_out(bin_b), .load_status_out(lstat), .driver_led_out(led));
    dcm_binary_in_func #(.CHANNEL(13)) i_di_a (.word_a_in(bin_a), .word_b_in(bin_b), .out_d_out(di13));
    dcm_binary_in_func #(.CHANNEL(213)) i_di_b (.word_a_in(bin_a), .word_b_in(bin_b), .out_d_out(di213));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // The request is held until waitrequest is sampled low; the slave's latency is not assumed.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !wr;
        wrq <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (wait_o !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wrq <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            report_and_stop();
        end
    endtask

    // Two registered stages lie between a condition input and the word handed to the binary input.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        logic [31:0] q;
        check("bin_a", {27'h0, bin_a}, 32'h0);
        check("lstat", {28'h0, lstat}, 32'h0);
        bus(1'b0, `DCM_OFS_MASK0, 32'h0, q);
        check("mask0", {27'h0, q[4:0]}, 32'h0);
        bus(1'b0, `DCM_OFS_TEMPHI, 32'h0, q);
        check("temphi", {16'h0, q[15:0]}, 32'h7FFF);
        bus(1'b0, 4'hC, 32'h0, q);
        check("unmapped", q, 32'h0);
    endtask

    task automatic t_conditions();
        logic [31:0] q;
        logic [4:0]  e;
        bus(1'b1, `DCM_OFS_CNTLIM0, 32'd100, q);
        bus(1'b1, `DCM_OFS_DURLIM0, 32'd50, q);
        bus(1'b1, `DCM_OFS_TEMPHI, 32'd100, q);
        bus(1'b1, `DCM_OFS_TEMPLO, 32'h0000_FF9C, q);
        bus(1'b1, `DCM_OFS_MASK0, 32'h1F, q);
        // Step five ends with every condition gone; from step one on the counter equals its limit.
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            cnt_a <= (i == 0) ? 32'd101 : 32'd100;
            dur_a <= (i == 1) ? 32'd51 : 32'd50;
            bad_a <= (i == 2);
            temp <= (i == 3) ? 16'd101 : (i == 4) ? 16'hFF9B : 16'h0;
            settle();
            e = (i < 5) ? 5'(1 << i) : 5'h00;
            check("bin_a", {27'h0, bin_a}, {27'h0, e});
            check("di13", {27'h0, di13}, {27'h0, e});
            check("bin_b", {27'h0, bin_b}, 32'h0);
            bus(1'b0, `DCM_OFS_FLAGS0, 32'h0, q);
            check("flags0", {27'h0, q[4:0]}, {27'h0, e});
        end
    endtask

    task automatic t_masks();
        logic [31:0] q;
        bus(1'b1, `DCM_OFS_MASK0, 32'h0A, q);
        bus(1'b1, `DCM_OFS_MASK1, 32'h1F, q);
        bus(1'b0, `DCM_OFS_MASK1, 32'h0, q);
        check("mask1", {27'h0, q[4:0]}, 32'h1F);
        @(posedge clk);
        cnt_a <= 32'd101;
        dur_a <= 32'd51;
        bad_a <= 1'b1;
        temp <= 16'd101;
        cnt_b <= 32'd1;
        dur_b <= 32'd1;
        bad_b <= 1'b1;
        settle();
        check("bin_a", {27'h0, bin_a}, 32'h0A);
        check("di213", {27'h0, di213}, 32'h0F);
    endtask

    // A reset in mid-run must clear the masks written before it and the words they produced.
    task automatic t_midreset();
        logic [31:0] q;
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("bin_a", {27'h0, bin_a}, 32'h0);
        check("bin_b", {27'h0, bin_b}, 32'h0);
        bus(1'b0, `DCM_OFS_MASK1, 32'h0, q);
        check("mask1", {27'h0, q[4:0]}, 32'h0);
    endtask

    task automatic t_pins();
        logic [31:0] q;
        logic [11:0] pv;
        for (int i = 0; i < 13; i++) begin
            pv = (i == 12) ? 12'hFFF : 12'(1 << i);
            @(posedge clk);
            {lo, up, dc2, dc1, drv1, drv0, sw} <= pv;
            settle();
            bus(1'b0, `DCM_OFS_PINS, 32'h0, q);
            check("pins", {16'h0, q[15:0]}, {20'h0, pv});
        end
    endtask

    task automatic t_load();
        logic [31:0] q;
        int          edges;
        @(posedge clk);
        {lo, up, dc2, dc1, drv1, drv0, sw} <= 12'h040;
        shrt <= 2'h1;
        settle();
        check("lstat", {28'h0, lstat}, 32'h1);
        @(posedge clk);
        shrt <= 2'h0;
        opn <= 2'h1;
        settle();
        check("lstat", {28'h0, lstat}, 32'h2);
        @(posedge clk);
        drv0 <= 1'b0;
        settle();
        bus(1'b0, `DCM_OFS_LOAD, 32'h0, q);
        check("load_reg", {28'h0, q[3:0]}, 32'h0);
        @(posedge clk);
        drv1 <= 1'b1;
        opn <= 2'h2;
        settle();
        check("lstat", {28'h0, lstat}, 32'h8);
        edges = 0;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (led[1] !== led[0]) edges++;
        end
        check("led_blinks", 32'(edges > 2 && edges < 18), 32'h1);
        @(posedge clk);
        opn <= 2'h0;
        settle();
        check("lstat", {28'h0, lstat}, 32'h0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_conditions();
        t_masks();
        t_midreset();
        t_pins();
        t_load();
        report_and_stop();
    end
endmodule
`default_nettype wire
